// *** rtl/umpc_pkg.sv ***
// Package: shared constants and carrier types for the modem pin and host control block
package umpc_pkg;

    // ------------------------------------------------------------
    // Register indices within a channel (three low address bits)
    // ------------------------------------------------------------
    localparam logic [2:0] UMPC_IDX_IER = 3'h1;   // Interrupt enable
    localparam logic [2:0] UMPC_IDX_ISR = 3'h2;   // Interrupt status (read)
    localparam logic [2:0] UMPC_IDX_MCR = 3'h4;   // Modem control
    localparam logic [2:0] UMPC_IDX_MSR = 3'h6;   // Modem status
    localparam logic [2:0] UMPC_IDX_SPR = 3'h7;   // Scratch

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int UMPC_MCR_DTR_BIT  = 0;         // Terminal-ready control
    localparam int UMPC_MCR_OUT_BIT  = 3;         // User output control
    localparam int UMPC_MSR_DDSR_BIT = 1;         // Delta data-set-ready
    localparam int UMPC_MSR_DSR_BIT  = 5;         // Data-set-ready level
    localparam int UMPC_IER_MS_BIT   = 3;         // Modem status enable
    localparam int UMPC_IER_EXT_BIT  = 0;         // External source enable

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] UMPC_RST_REG  = 8'h00; // Registers clear
    localparam logic [7:0] UMPC_ISR_IDLE = 8'h01; // No interrupt pending
    localparam logic       UMPC_RST_PIN  = 1'b1;  // Active-low pins idle high
    localparam logic [7:0] UMPC_BUS_IDLE = 8'h00; // Read data when idle

    // ------------------------------------------------------------
    // Host access carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic       cs_n;   // Chip select, active low
        logic       chan;   // Channel select bit
        logic [2:0] addr;   // Register index
        logic       rd_wr;  // 1 = read, 0 = write
        logic [7:0] wdata;  // Write data
    } umpc_host_req_t;

    // Channel pin carrier
    typedef struct packed {
        logic terminal_ready_n;  // Terminal-ready pin
        logic user_out_n;        // User output pin
        logic tx_enable;         // Serial transmit enable
        logic rx_enable;         // Serial receive enable
    } umpc_chan_pins_t;

endpackage

// *** rtl/umpc_channel.sv ***
// Module: one channel's register set, pin drivers and interrupt request
module umpc_channel
    import umpc_pkg::*;
(
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            srst,
    // Register access, already decoded for this channel
    input  wire logic            wr_en,
    input  wire logic [2:0]      addr,
    input  wire logic [7:0]      wdata,
    output logic [7:0]           rdata,
    // Synchronised data-set-ready level, active low
    input  wire logic            dsr_n_sync,
    // External interrupt source from the serial datapath
    input  wire logic            ext_irq,
    // Pin outputs
    output umpc_chan_pins_t      pins,
    output logic                 irq
);

    logic [7:0] modem_control_reg;   // Host written modem control
    logic [7:0] ier;                 // Interrupt enable register
    logic [7:0] scratch;             // Scratch register
    logic       dsr_prev;            // Last sampled level for delta
    logic       ddsr;                // Sticky delta flag
    logic [7:0] modem_status_reg;    // Assembled status view

    // ------------------------------------------------------------
    // Host writes
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            modem_control_reg <= UMPC_RST_REG;
            ier               <= UMPC_RST_REG;
            scratch           <= UMPC_RST_REG;
        end else if (wr_en) begin
            case (addr)
                UMPC_IDX_MCR: modem_control_reg <= wdata;
                UMPC_IDX_IER: ier <= wdata;
                UMPC_IDX_SPR: scratch <= wdata;
                default: ;   // Other indices belong to the datapath
            endcase
        end
    end

    // ------------------------------------------------------------
    // Data-set-ready capture and delta flag
    // ------------------------------------------------------------
    // Delta stays set until reset; there is no clear path, so a polling
    // host must not expect the modem status interrupt to drop by itself
    always_ff @(posedge clk) begin
        if (srst) begin
            dsr_prev <= UMPC_RST_PIN;
            ddsr     <= 1'b0;
        end else begin
            dsr_prev <= dsr_n_sync;
            if (dsr_prev != dsr_n_sync) begin
                ddsr <= 1'b1;
            end
        end
    end

    always_comb begin
        modem_status_reg                    = UMPC_RST_REG;
        modem_status_reg[UMPC_MSR_DSR_BIT]  = ~dsr_prev;
        modem_status_reg[UMPC_MSR_DDSR_BIT] = ddsr;
    end

    // ------------------------------------------------------------
    // Read mux, registered
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= UMPC_BUS_IDLE;
        end else begin
            case (addr)
                UMPC_IDX_IER: rdata <= ier;
                UMPC_IDX_ISR: rdata <= irq ? UMPC_RST_REG : UMPC_ISR_IDLE;
                UMPC_IDX_MCR: rdata <= modem_control_reg;
                UMPC_IDX_MSR: rdata <= modem_status_reg;
                UMPC_IDX_SPR: rdata <= scratch;
                default:      rdata <= UMPC_BUS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pins and interrupt, registered; interrupt gated by enables
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            pins.terminal_ready_n <= UMPC_RST_PIN;
            pins.user_out_n       <= UMPC_RST_PIN;
            pins.tx_enable        <= 1'b0;
            pins.rx_enable        <= 1'b0;
            irq                   <= 1'b0;
        end else begin
            pins.terminal_ready_n <= ~modem_control_reg[UMPC_MCR_DTR_BIT];
            pins.user_out_n       <= ~modem_control_reg[UMPC_MCR_OUT_BIT];
            pins.tx_enable        <= 1'b1;
            pins.rx_enable        <= 1'b1;
            irq <= (ier[UMPC_IER_MS_BIT] & ddsr) |
                   (ier[UMPC_IER_EXT_BIT] & ext_irq);
        end
    end

endmodule

// *** rtl/umpc_top.sv ***
// Module: dual-channel modem pin, interrupt and host access block
module umpc_top
    import umpc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // Host bus
    input  wire logic       cs_n,
    input  wire logic       channel_select_bit,
    input  wire logic [2:0] addr,
    input  wire logic       rd_wr,
    input  wire logic [7:0] data_in,
    output logic [7:0]      data_out,
    output logic            data_oe,
    // Modem inputs, asynchronous pins
    input  wire logic       data_set_ready_n_chan_a,
    input  wire logic       data_set_ready_n_chan_b,
    // Interrupt sources from the serial datapath
    input  wire logic       ext_irq_chan_a,
    input  wire logic       ext_irq_chan_b,
    // Modem and user outputs
    output logic            terminal_ready_n_chan_a,
    output logic            terminal_ready_n_chan_b,
    output logic            user_out_n_chan_a,
    output logic            user_out_n_chan_b,
    // Serial enables
    output logic            tx_enable_chan_a,
    output logic            tx_enable_chan_b,
    output logic            rx_enable_chan_a,
    output logic            rx_enable_chan_b,
    // Open-drain interrupt pin
    output logic            irq_n_out,
    output logic            irq_n_oe
);

    // ------------------------------------------------------------
    // Input synchronisers, first stage read only by second
    // ------------------------------------------------------------
    logic [1:0] dsr_meta;   // First stage
    logic [1:0] dsr_sync;   // Second stage

    always_ff @(posedge clk) begin
        if (srst) begin
            dsr_meta <= {2{UMPC_RST_PIN}};
            dsr_sync <= {2{UMPC_RST_PIN}};
        end else begin
            dsr_meta <= {data_set_ready_n_chan_b, data_set_ready_n_chan_a};
            dsr_sync <= dsr_meta;
        end
    end

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    umpc_host_req_t req;          // Bundled request
    logic [1:0]     wr_en;        // Per-channel write strobe
    logic [7:0]     rdata [2];    // Per-channel read data
    logic [1:0]     irq_ch;       // Per-channel request
    logic [1:0]     ext_irq;      // Datapath sources
    umpc_chan_pins_t pins [2];    // Per-channel pin state
    logic           sel_q;        // Channel select of the previous cycle

    assign req = '{cs_n: cs_n, chan: channel_select_bit, addr: addr,
                   rd_wr: rd_wr, wdata: data_in};
    assign ext_irq = {ext_irq_chan_b, ext_irq_chan_a};

    // Write to one channel only; cs_n must already be settled by the host
    assign wr_en[0] = !req.cs_n && !req.rd_wr && !req.chan;
    assign wr_en[1] = !req.cs_n && !req.rd_wr &&  req.chan;

    // ------------------------------------------------------------
    // Channel instances
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_chan
            umpc_channel u_chan (
                .clk        (clk),
                .srst       (srst),
                .wr_en      (wr_en[g]),
                .addr       (req.addr),
                .wdata      (req.wdata),
                .rdata      (rdata[g]),
                .dsr_n_sync (dsr_sync[g]),
                .ext_irq    (ext_irq[g]),
                .pins       (pins[g]),
                .irq        (irq_ch[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Read return; channel registered to match read data latency
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            sel_q   <= 1'b0;
            data_oe <= 1'b0;
        end else begin
            sel_q   <= req.chan;
            data_oe <= !req.cs_n && req.rd_wr;
        end
    end

    // Read data is already a flip-flop in each channel
    assign data_out = data_oe ? rdata[sel_q] : UMPC_BUS_IDLE;

    // ------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------
    assign terminal_ready_n_chan_a = pins[0].terminal_ready_n;
    assign terminal_ready_n_chan_b = pins[1].terminal_ready_n;
    assign user_out_n_chan_a       = pins[0].user_out_n;
    assign user_out_n_chan_b       = pins[1].user_out_n;
    assign tx_enable_chan_a        = pins[0].tx_enable;
    assign tx_enable_chan_b        = pins[1].tx_enable;
    assign rx_enable_chan_a        = pins[0].rx_enable;
    assign rx_enable_chan_b        = pins[1].rx_enable;

    // Wired-OR of both channels; the pin is never driven high so an
    // external pull-up can share the line with other devices
    assign irq_n_oe  = |irq_ch;
    assign irq_n_out = 1'b0;

endmodule

// *** verification/umpc_assertions.sv ***
// Checker: reset, pin and host bus relations at the top module's ports
module umpc_assertions
    import umpc_pkg::*;
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       srst,
    // Host bus
    input wire logic       cs_n,
    input wire logic       channel_select_bit,
    input wire logic [2:0] addr,
    input wire logic       rd_wr,
    input wire logic [7:0] data_in,
    input wire logic       data_oe,
    // Modem, user and serial pins
    input wire logic       terminal_ready_n_chan_a,
    input wire logic       terminal_ready_n_chan_b,
    input wire logic       user_out_n_chan_a,
    input wire logic       user_out_n_chan_b,
    input wire logic       tx_enable_chan_a,
    input wire logic       tx_enable_chan_b,
    input wire logic       rx_enable_chan_a,
    input wire logic       rx_enable_chan_b,
    // Open-drain interrupt
    input wire logic       irq_n_out,
    input wire logic       irq_n_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // Decoded requests
    // ----------------------------------------
    logic rd_req;   // Read held on the bus
    logic wr_a;     // Control write, channel A
    logic wr_b;     // Control write, channel B
    assign rd_req = !cs_n && rd_wr;
    assign wr_a   = !cs_n && !rd_wr && !channel_select_bit && addr == UMPC_IDX_MCR;
    assign wr_b   = !cs_n && !rd_wr && channel_select_bit && addr == UMPC_IDX_MCR;

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    // Reset checks are not masked by reset: they watch the reset itself
    property p_rst_pins; @(posedge clk) srst |=> terminal_ready_n_chan_a
        && terminal_ready_n_chan_b && user_out_n_chan_a && user_out_n_chan_b; endproperty
    a_rst_pins: assert property (p_rst_pins) else $error("pins low after reset");
    property p_rst_ser; @(posedge clk) srst |=> !(tx_enable_chan_a || tx_enable_chan_b
        || rx_enable_chan_a || rx_enable_chan_b); endproperty
    a_rst_ser: assert property (p_rst_ser) else $error("serial enabled in reset");
    property p_rst_oe; @(posedge clk) srst |=> !data_oe && !irq_n_oe; endproperty
    a_rst_oe: assert property (p_rst_oe) else $error("drivers on in reset");
    property p_od; @(posedge clk) disable iff (srst) irq_n_oe |-> !irq_n_out; endproperty
    a_od: assert property (p_od) else $error("interrupt driven high");
    property p_oe_cause; @(posedge clk) disable iff (srst) data_oe |-> $past(rd_req); endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("bus driven without read");
    property p_oe_rd; @(posedge clk) disable iff (srst) rd_req ##1 rd_req |-> data_oe; endproperty
    a_oe_rd: assert property (p_oe_rd) else $error("held read not answered");
    // Later writes are excluded so the checked value is this write's
    property p_dtr_a; @(posedge clk) disable iff (srst)
        wr_a && data_in[UMPC_MCR_DTR_BIT] ##1 !wr_a |-> ##2 !terminal_ready_n_chan_a; endproperty
    a_dtr_a: assert property (p_dtr_a) else $error("terminal ready not low");
    property p_uo_b; @(posedge clk) disable iff (srst) wr_b ##1 !wr_b |-> ##2
        user_out_n_chan_b == !$past(data_in[UMPC_MCR_OUT_BIT], 3); endproperty
    a_uo_b: assert property (p_uo_b) else $error("user output wrong");

    // Main scenarios reached
    c_irq: cover property (@(posedge clk) !irq_n_oe ##1 irq_n_oe);
    c_rd: cover property (@(posedge clk) rd_req ##1 data_oe);
    c_wr_b: cover property (@(posedge clk) wr_b ##1 !wr_b);
endmodule

bind umpc_top umpc_assertions u_chk (.clk, .srst, .cs_n, .channel_select_bit, .addr, .rd_wr,
    .data_in, .data_oe, .terminal_ready_n_chan_a, .terminal_ready_n_chan_b, .user_out_n_chan_a,
    .user_out_n_chan_b, .tx_enable_chan_a, .tx_enable_chan_b, .rx_enable_chan_a,
    .rx_enable_chan_b, .irq_n_out, .irq_n_oe);

// *** verification/umpc_host_model.sv ***
// Partner: host CPU model issuing byte accesses on the parallel bus
module umpc_host_model
    import umpc_pkg::*;
(
    // Clock
    input  wire logic       clk,
    // Bus toward the device
    output umpc_host_req_t  req,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle bus at time zero
    initial req = '{cs_n: 1'b1, chan: 1'b0, addr: 3'h0, rd_wr: 1'b1, wdata: 8'h00};

    // Write: request held past one sampling edge, left up for back-to-back use
    task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
        req = '{cs_n: 1'b0, chan: ch, addr: a, rd_wr: 1'b0, wdata: d};
        @(posedge clk);
        #1;
    endtask

    // Read: channel picked by select bit; data taken at the edge it is held
    task automatic rd(input logic ch, input logic [2:0] a, output logic [7:0] d);
        req = '{cs_n: 1'b0, chan: ch, addr: a, rd_wr: 1'b1, wdata: ~req.wdata};
        @(posedge clk);
        #1;
        d = data_oe ? data_out : 8'hXX;
    endtask

    // Release: stale write data is flipped so it never looks valid
    task automatic idle;
        req.cs_n = 1'b1;
        req.wdata = ~req.wdata;
        @(posedge clk);
        #1;
    endtask
endmodule

// *** verification/test_uart_modem_pins_host_control.sv ***
// Testbench: hand-written scenarios for the modem pin and host control block
module test_uart_modem_pins_host_control
    import umpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic           clk, srst, data_oe, irq_n_out, irq_n_oe;
    logic [7:0]     data_out, d;
    umpc_host_req_t req;
    logic           data_set_ready_n_chan_a, data_set_ready_n_chan_b;
    logic           ext_irq_chan_a, ext_irq_chan_b;
    logic           terminal_ready_n_chan_a, terminal_ready_n_chan_b;
    logic           user_out_n_chan_a, user_out_n_chan_b;
    logic           tx_enable_chan_a, tx_enable_chan_b, rx_enable_chan_a, rx_enable_chan_b;
    int             n_mismatch = 0;
    int             check_count = 0;

    umpc_top u_dut (.clk, .srst, .cs_n(req.cs_n), .channel_select_bit(req.chan),
        .addr(req.addr), .rd_wr(req.rd_wr), .data_in(req.wdata), .data_out, .data_oe,
        .data_set_ready_n_chan_a, .data_set_ready_n_chan_b, .ext_irq_chan_a, .ext_irq_chan_b,
        .terminal_ready_n_chan_a, .terminal_ready_n_chan_b, .user_out_n_chan_a,
        .user_out_n_chan_b, .tx_enable_chan_a, .tx_enable_chan_b, .rx_enable_chan_a,
        .rx_enable_chan_b, .irq_n_out, .irq_n_oe);
    umpc_host_model u_host (.clk, .req, .data_out, .data_oe);

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Modem and user pins high nibble, serial enables low nibble
    function automatic logic [7:0] pins();
        return {terminal_ready_n_chan_a, terminal_ready_n_chan_b, user_out_n_chan_a,
            user_out_n_chan_b, tx_enable_chan_a, tx_enable_chan_b, rx_enable_chan_a,
            rx_enable_chan_b};
    endfunction
    // Bounded wait on the interrupt pull-down
    task automatic wait_irq(input logic exp);
        int i;
        for (i = 0; i < 20 && irq_n_oe !== exp; i++) cyc(1);
        chk("irq_n_oe", {7'h00, irq_n_oe}, {7'h00, exp});
        if (i == 20) end_sim();
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        srst = 1'b1;
        cyc(4);
        chk("pins", pins(), 8'hF0);
        chk("oe", {6'h00, data_oe, irq_n_oe}, 8'h00);
        srst = 1'b0;
        cyc(1);
        chk("ser_on", pins() & 8'h0F, 8'h0F);
    endtask
    task automatic t_mcr;
        u_host.wr(0, UMPC_IDX_MCR, 8'h09);
        u_host.idle();
        cyc(1);
        chk("pins_a", pins() & 8'hF0, 8'h50);
        u_host.rd(0, UMPC_IDX_MCR, d);
        chk("mcr_a", d, 8'h09);
        u_host.wr(1, UMPC_IDX_MCR, 8'h08);
        u_host.wr(0, UMPC_IDX_MCR, 8'h00);
        u_host.idle();
        cyc(1);
        chk("pins_b", pins() & 8'hF0, 8'hE0);
    endtask
    // Back-to-back writes, one to a reserved index
    task automatic t_regs;
        u_host.wr(0, UMPC_IDX_SPR, 8'h5A);
        u_host.wr(1, UMPC_IDX_SPR, 8'hA5);
        u_host.wr(0, 3'h3, 8'hFF);
        u_host.rd(0, UMPC_IDX_SPR, d);
        chk("spr_a", d, 8'h5A);
        u_host.rd(1, UMPC_IDX_SPR, d);
        chk("spr_b", d, 8'hA5);
        u_host.rd(0, 3'h3, d);
        chk("rsvd", d, 8'h00);
        u_host.idle();
        cyc(1);
        chk("oe_off", {7'h00, data_oe}, 8'h00);
    endtask
    task automatic t_dsr;
        data_set_ready_n_chan_a = 1'b0;
        cyc(6);
        u_host.rd(0, UMPC_IDX_MSR, d);
        chk("msr_a", d & 8'h22, 8'h22);
        u_host.rd(1, UMPC_IDX_MSR, d);
        chk("msr_b", d & 8'h22, 8'h00);
    endtask
    // Masked, enabled, polled per channel, masked again, then channel A modem status enabled
    task automatic t_irq;
        ext_irq_chan_b = 1'b1;
        cyc(6);
        chk("masked", {7'h00, irq_n_oe}, 8'h00);
        u_host.wr(1, UMPC_IDX_IER, 8'h01);
        u_host.idle();
        wait_irq(1'b1);
        u_host.rd(1, UMPC_IDX_ISR, d);
        chk("isr_b", d, 8'h00);
        u_host.rd(0, UMPC_IDX_ISR, d);
        chk("isr_a", d, UMPC_ISR_IDLE);
        u_host.wr(1, UMPC_IDX_IER, 8'h00);
        u_host.idle();
        wait_irq(1'b0);
        u_host.wr(0, UMPC_IDX_IER, 8'h08);
        u_host.idle();
        wait_irq(1'b1);
    endtask

    // Verdict and end of run
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence, with a second reset after the scenarios and before the final scratch read
    initial begin
        srst = 1'b1;
        data_set_ready_n_chan_a = 1'b1;
        data_set_ready_n_chan_b = 1'b1;
        ext_irq_chan_a = 1'b0;
        ext_irq_chan_b = 1'b0;
        t_reset();
        t_mcr();
        t_regs();
        t_dsr();
        t_irq();
        t_reset();
        u_host.rd(0, UMPC_IDX_SPR, d);
        chk("spr_rst", d, UMPC_RST_REG);
        end_sim();
    end
endmodule
